// file: bench/asp_chk.sv
// Concurrent checks on the serial port's pins and register answers
`timescale 1ns/1ps
module asp_chk (
   input wire logic        i_core_clk,
   input wire logic        i_srst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire logic        o_serial_out_pin,
   input wire logic        o_serial_out_pin_oe,
   input wire logic        o_request_to_send_pin_oe,
   input wire logic        o_rx_irq,
   input wire logic        o_err_irq,
   input wire logic        o_wake_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   logic [15:0] mode_reg;
   logic        txen_reg;
   wire         acc = i_psel && i_penable;
   wire         wr  = acc && i_pwrite;
   wire         hit = (i_paddr <= 8'h10) && (i_paddr[1:0] == 2'h0);
   // Shadow of control bits; hardware clears of the wake bit are not tracked here
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         mode_reg <= 16'h0000;
         txen_reg <= 1'b0;
      end else if (wr && i_paddr == 8'h00) mode_reg <= i_pwdata[15:0];
      else if (wr && i_paddr == 8'h04) txen_reg <= i_pwdata[10];
   end
   sequence s_stat_setup;
      i_psel && !i_penable && !i_pwrite && i_paddr == 8'h04;
   endsequence
   chk_tx_pin_own: assert property (o_serial_out_pin_oe == (mode_reg[15] && txen_reg))
      else $error("transmit pin ownership wrong");
   chk_rts_pin_use: assert property (o_request_to_send_pin_oe == (mode_reg[15] && mode_reg[9:8] != 2'h0))
      else $error("request pin ownership wrong");
   chk_start_len: assert property ((!mode_reg[12] && !mode_reg[6] && !mode_reg[3]
      && $fell(o_serial_out_pin)) |-> !o_serial_out_pin [*8]) else $error("low bit too short");
   chk_rx_avail: assert property (s_stat_setup |=> o_prdata[0] == $past(o_rx_irq))
      else $error("data available flag disagrees");
   chk_err_flags: assert property (s_stat_setup |=> (|o_prdata[3:1]) == $past(o_err_irq))
      else $error("error flags disagree with error line");
   chk_unmapped_err: assert property (acc |-> o_pslverr == !hit)
      else $error("slave error on wrong address");
   chk_wake_once: assert property (o_wake_irq |-> mode_reg[7] ##1 !o_wake_irq)
      else $error("wake pulse wrong");
   chk_reset_idle: assert property (disable iff (1'b0) i_srst |=> o_serial_out_pin && !o_serial_out_pin_oe)
      else $error("line not idle after reset");
endmodule : asp_chk
bind asp_top asp_chk i_asp_chk (.*);

// file: bench/asp_remote.sv
// Remote serial node: sends frames and decodes the device's line
`timescale 1ns/1ps
module asp_remote (
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_line
);
   int         per  = 16;     // Clocks per bit
   int         nb   = 8;      // Data bits
   int         par  = 0;      // 0 none, 1 even, 2 odd
   int         lrun = 0;
   int         lmax = 0;
   logic       inv  = 1'b0;   // Idle low when set
   logic       ln   = 1'b1;
   logic [9:0] got[$];        // Bit 9 marks bad parity or stop
   assign o_line = ln ^ inv;
   // One frame; bad turns the parity bit round
   task automatic send(input logic [8:0] d, input logic bad);
      ln <= 1'b0;
      repeat (per) @(posedge i_clk);
      for (int i = 0; i < nb; i++) begin
         ln <= d[i];
         repeat (per) @(posedge i_clk);
      end
      if (par != 0) begin
         ln <= ^d[7:0] ^ (par == 2) ^ bad;
         repeat (per) @(posedge i_clk);
      end
      ln <= 1'b1;
      repeat (per) @(posedge i_clk);
   endtask : send
   // Decode at mid-bit; a low stop is kept as an error
   initial forever begin : rx
      logic [9:0] v;
      @(negedge i_line);
      v = 10'h000;
      repeat (per / 2) @(posedge i_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (per) @(posedge i_clk);
         v[i] = i_line;
      end
      if (par != 0) begin
         repeat (per) @(posedge i_clk);
         v[9] = i_line ^ (^v[7:0]) ^ (par == 2);
      end
      repeat (per) @(posedge i_clk);
      v[9] = v[9] | !i_line;
      got.push_back(v);
   end
   // Longest low run, for break length
   always @(posedge i_clk) begin
      lrun = i_line ? 0 : lrun + 1;
      if (lrun > lmax) lmax = lrun;
   end
endmodule : asp_remote

// file: bench/asp_top_tb.sv
// Self-checking bench of the serial port against a remote node
`timescale 1ns/1ps
module asp_top_tb;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, idle = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [8:0]  d;
   logic        pready, pslverr, slv, txd, txoe, rxd, err_irq, wake_irq, tx_irq;
   int          err_total = 0, samples_checked = 0, cyc = 0, wakes = 0, t0 = 0;
   wire         line = txoe ? txd : 1'b1;   // Pulled up when released
   always #2.5 clk = ~clk;
   asp_top i_asp_top (.i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_idle(idle), .i_sleep(sleep), .i_serial_in_pin(rxd),
      .i_clear_to_send_pin_n(1'b0), .o_serial_out_pin(txd), .o_serial_out_pin_oe(txoe),
      .o_request_to_send_pin_n(), .o_request_to_send_pin_oe(), .o_tx_irq(tx_irq), .o_rx_irq(),
      .o_err_irq(err_irq), .o_wake_irq(wake_irq));
   asp_remote i_asp_remote (.i_clk(clk), .i_line(line), .o_line(rxd));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, v};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 16'h0000);
      chk(q, exp);
   endtask : rd
   // Poll until shifter empty and receiver idle
   task automatic settle;
      do apb(1'b0, 8'h04, 16'h0000); while (!(q[8] && q[4]));
   endtask : settle
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Cycle ceiling and wake pulse count
   always @(posedge clk) begin
      cyc++;
      if (wake_irq === 1'b1) wakes++;
      if (cyc == 30000) begin
         err_total++;
         report_and_stop;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0110);
      apb(1'b0, 8'h14, 16'h0000);
      chk(slv, 1'b1);
      apb(1'b1, 8'h00, 16'h8100);
      apb(1'b1, 8'h04, 16'h0400);
      // One in the shifter, four queued
      for (int i = 0; i < 5; i++) apb(1'b1, 8'h08, {12'h003, 4'(i)});
      rd(8'h04, 32'h0610);
      chk(tx_irq, 1'b0);
      settle;
      for (int i = 0; i < 5; i++) chk(i_asp_remote.got.pop_front(), {28'h0000003, 4'(i)});
      // Every format, both directions
      for (int f = 0; f < 4; f++) begin
         d = {f == 3, 8'hA5};
         apb(1'b1, 8'h00, {13'h1020, 2'(f), 1'b0});
         i_asp_remote.nb = (f == 3) ? 9 : 8;
         i_asp_remote.par = (f == 3) ? 0 : f;
         apb(1'b1, 8'h08, {7'h00, d});
         settle;
         chk(i_asp_remote.got.pop_front(), {23'h0, d});
         i_asp_remote.send(d, 1'b0);
         settle;
         rd(8'h0C, {23'h0, d});
      end
      apb(1'b1, 8'h00, 16'h8102);
      i_asp_remote.nb = 8;
      i_asp_remote.par = 1;
      i_asp_remote.send(9'h033, 1'b1);
      settle;
      rd(8'h04, 32'h0519);
      chk(err_irq, 1'b1);
      rd(8'h0C, 32'h0033);
      rd(8'h04, 32'h0510);
      // Overrun, then clearing it empties the queue
      for (int i = 0; i < 5; i++) i_asp_remote.send({5'h00, 4'(i)}, 1'b0);
      settle;
      rd(8'h04, 32'h0513);
      apb(1'b1, 8'h04, 16'h0400);
      rd(8'h04, 32'h0510);
      i_asp_remote.lmax = 0;
      apb(1'b1, 8'h04, 16'h0C00);
      settle;
      chk(i_asp_remote.lmax, 208);
      rd(8'h04, 32'h0510);
      i_asp_remote.got.delete();
      apb(1'b1, 8'h00, 16'h8106);
      apb(1'b1, 8'h04, 16'h0420);
      i_asp_remote.nb = 9;
      i_asp_remote.par = 0;
      i_asp_remote.send(9'h055, 1'b0);
      i_asp_remote.send(9'h1AA, 1'b0);
      settle;
      rd(8'h0C, 32'h01AA);
      rd(8'h04, 32'h0530);
      apb(1'b1, 8'h04, 16'h0400);
      apb(1'b1, 8'h00, 16'h8140);
      i_asp_remote.nb = 8;
      apb(1'b1, 8'h08, 16'h005A);
      settle;
      rd(8'h0C, 32'h005A);
      chk(i_asp_remote.got.size(), 0);
      apb(1'b1, 8'h00, 16'h8108);
      i_asp_remote.per = 4;
      i_asp_remote.send(9'h096, 1'b0);
      apb(1'b1, 8'h08, 16'h0069);
      settle;
      rd(8'h0C, 32'h0096);
      chk(i_asp_remote.got.pop_front(), 32'h0069);
      i_asp_remote.per = 16;
      apb(1'b1, 8'h00, 16'h8080);
      sleep <= 1'b1;
      i_asp_remote.send(9'h0F0, 1'b0);
      sleep <= 1'b0;
      chk(wakes, 1);
      rd(8'h00, 32'h8000);
      // Turn off while the idle level flips, so no false start
      apb(1'b1, 8'h00, 16'h0010);
      i_asp_remote.inv <= 1'b1;
      apb(1'b1, 8'h00, 16'h8010);
      i_asp_remote.send(9'h03C, 1'b0);
      settle;
      rd(8'h0C, 32'h003C);
      // Idle-halt holds a queued frame until Idle ends
      apb(1'b1, 8'h00, 16'hA010);
      idle <= 1'b1;
      apb(1'b1, 8'h08, 16'h00C3);
      rd(8'h04, 32'h0410);
      idle <= 1'b0;
      settle;
      chk(i_asp_remote.got.pop_front(), 32'h00C3);
      // Auto-rate at half speed gives divisor 1, then two stop bits
      i_asp_remote.per = 32;
      apb(1'b1, 8'h00, 16'h8031);
      i_asp_remote.send(9'h055, 1'b0);
      rd(8'h10, 32'h0001);
      rd(8'h00, 32'h8011);
      t0 = cyc;
      apb(1'b1, 8'h08, 16'h0000);
      settle;
      chk((cyc - t0) / 32, 11);
      chk(i_asp_remote.got.pop_front(), 32'h0);
      report_and_stop;
   end
endmodule : asp_top_tb

// file: rtl/asp_params.svh
// Offsets, field positions, reset values and counts of the serial port
// How it works
// - Module-on gives pins to port, else idle
// - Idle-halt stops module during device Idle
// - Infrared coder works only in 16x mode
// - Request pin: simplex or flow control
// - Pin-use field picks handshake or clock pins
// - Wake: falling edge interrupts, rising clears bit
// - Loopback-select enters diagnostic loopback
// - Auto-rate measures 55h sync, then clears
// - Receive-polarity sets idle level of input
// - High-speed: 4 ticks per bit, else 16
// - Frame format: 9-bit, odd, even, none
// - Stop-count: two stop bits or one
// - Transmit-enable owns pin; clearing flushes queue
// - Both directions queue four characters
// - Transmit-full flag while queue is full
// - Shifter-empty when shifter and queue empty
// - Ninth bit one marks an address
// - Errors share one interrupt of their own
// - Clock output at tick rate: sixteen times bit rate, four in high-speed
// - Rate generator uses 16-bit divisor
// - Address detect only in 9-bit format
// - Parity/framing flags describe queue head, read-only
// - Clearing overrun empties queue and shifter
// - Data-available while receive queue holds data
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ASP_OFF_MODE   8'h00
`define ASP_OFF_STAT   8'h04
`define ASP_OFF_TXD    8'h08
`define ASP_OFF_RXD    8'h0C
`define ASP_OFF_DIV    8'h10
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ASP_B_ON       15
`define ASP_B_IDLH     13
`define ASP_B_INFRARED_ENABLE     12
`define ASP_B_REQUEST_PIN_MODE    11
`define ASP_B_PUSE     8
`define ASP_B_WAKE     7
`define ASP_B_LPBK     6
`define ASP_B_AUTO_RATE_MEASURE    5
`define ASP_B_RINV     4
`define ASP_B_HIGH_SPEED_SAMPLING     3
`define ASP_B_FMT      1
`define ASP_B_STOP     0
`define ASP_B_BRK      11
`define ASP_B_TXEN     10
`define ASP_B_TXBF     9
`define ASP_B_SHIFTER_EMPTY_FLAG     8
`define ASP_B_ADDRESS_DETECT_ENABLE    5
`define ASP_B_RIDLE    4
`define ASP_B_PARITY_ERROR_FLAG     3
`define ASP_B_FRAMING_ERROR_FLAG     2
`define ASP_B_OVERRUN_FLAG     1
`define ASP_B_RXDA     0
// ---------------------------------------------------------------
// Reset values, masks and counts
// ---------------------------------------------------------------
`define ASP_MODE_RST   16'h0000
`define ASP_MODE_WMASK 16'hBBFF
`define ASP_DIV_RST    16'h0000
`define ASP_LAST_STD   4'hF
`define ASP_LAST_HS    4'h3
`define ASP_HALF_STD   4'h8
`define ASP_HALF_HS    4'h2
`define ASP_BRK_BITS   4'hC
`define ASP_IR_PULSE   4'h3
`define ASP_IR_HOLD    5'h10
`define ASP_AB_FALLS   3'h4
`define ASP_AB_SH_STD  7
`define ASP_AB_SH_HS   5
`endif

// file: rtl/asp_pkg.sv
// Types shared by the serial port
package asp_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_START = 5'b00010,
      ST_DATA  = 5'b00100,
      ST_PAR   = 5'b01000,
      ST_STOP  = 5'b10000
   } asp_st_t;
   typedef logic [1:0] asp_fmt_t;
endpackage : asp_pkg

// file: rtl/asp_top.sv
// Serial port core: APB registers, rate generator, queues, framer
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_top
   import asp_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int ABW   = 24
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_idle,
   input  wire logic        i_sleep,
   input  wire logic        i_serial_in_pin,
   input  wire logic        i_clear_to_send_pin_n,
   output logic             o_serial_out_pin,
   output logic             o_serial_out_pin_oe,
   output logic             o_request_to_send_pin_n,
   output logic             o_request_to_send_pin_oe,
   output logic             o_tx_irq,
   output logic             o_rx_irq,
   output logic             o_err_irq,
   output logic             o_wake_irq
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("DEPTH must be a power of two, at least 2");
   end

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = p + AW'(1);
   endfunction : nxt
   function automatic logic par_of(input logic [7:0] d, input logic odd);
      par_of = (^d) ^ odd;
   endfunction : par_of

   // ---------------------------------------------------------------
   // Registers and bus decode
   // ---------------------------------------------------------------
   logic [15:0] mode_reg, mode_next, div_reg;
   logic        brk_reg, brk_next, txen_reg, address_detect_enable_reg, overrun_flag_reg, overrun_flag_next;
   logic [31:0] prdata_reg;
   wire acc    = i_psel & i_penable;
   wire wr     = acc & i_pwrite;
   wire hit_md = i_paddr == `ASP_OFF_MODE;
   wire hit_st = i_paddr == `ASP_OFF_STAT;
   wire hit_tx = i_paddr == `ASP_OFF_TXD;
   wire hit_rx = i_paddr == `ASP_OFF_RXD;
   wire hit_dv = i_paddr == `ASP_OFF_DIV;
   wire wr_md  = wr & hit_md;
   wire wr_st  = wr & hit_st;
   wire rd_rx  = acc & ~i_pwrite & hit_rx;
   assign o_pready  = 1'b1;
   assign o_pslverr = acc & ~(hit_md | hit_st | hit_tx | hit_rx | hit_dv);
   assign o_prdata  = prdata_reg;

   wire       on    = mode_reg[`ASP_B_ON];
   wire       high_speed_sampling  = mode_reg[`ASP_B_HIGH_SPEED_SAMPLING];
   wire       ir_on = mode_reg[`ASP_B_INFRARED_ENABLE] & ~high_speed_sampling;
   wire       lpbk  = mode_reg[`ASP_B_LPBK];
   wire       abd   = mode_reg[`ASP_B_AUTO_RATE_MEASURE];
   wire [1:0] puse  = mode_reg[`ASP_B_PUSE +: 2];
   asp_fmt_t  fmt;
   assign fmt = mode_reg[`ASP_B_FMT +: 2];
   wire       nine  = fmt == 2'b11;
   wire       haspr = fmt == 2'b01 || fmt == 2'b10;
   wire       oddp  = fmt == 2'b10;
   wire       run   = on & ~i_sleep & ~(mode_reg[`ASP_B_IDLH] & i_idle);
   wire [3:0] last  = high_speed_sampling ? `ASP_LAST_HS : `ASP_LAST_STD;
   wire [3:0] half  = high_speed_sampling ? `ASP_HALF_HS : `ASP_HALF_STD;

   // ---------------------------------------------------------------
   // Rate generator and tick-rate clock output
   // ---------------------------------------------------------------
   logic [15:0] brg_cnt_reg;
   logic        bclk_reg;
   wire tick = run & (brg_cnt_reg == div_reg);
   always_ff @(posedge i_core_clk) begin
      if (i_srst | ~run | tick) brg_cnt_reg <= 16'h0000;
      else brg_cnt_reg <= brg_cnt_reg + 16'h0001;
      bclk_reg <= run & (brg_cnt_reg <= {1'b0, div_reg[15:1]});
   end

   // ---------------------------------------------------------------
   // Queues
   // ---------------------------------------------------------------
   logic [8:0]    txq [DEPTH];
   logic [10:0]   rxq [DEPTH];
   logic [AW-1:0] txw_reg, txr_reg, rxw_reg, rxr_reg;
   logic [AW:0]   txc_reg, rxc_reg;
   wire tx_full  = txc_reg == (AW+1)'(DEPTH);
   wire tx_empty = txc_reg == '0;
   wire rx_full  = rxc_reg == (AW+1)'(DEPTH);
   wire rx_empty = rxc_reg == '0;
   wire [10:0] rx_head = rxq[rxr_reg];
   wire tx_flush = ~on | ~txen_reg;
   wire rx_flush = ~on | (wr_st & ~i_pwdata[`ASP_B_OVERRUN_FLAG] & overrun_flag_reg);
   wire tx_push  = wr & hit_tx & ~tx_full & ~tx_flush;
   wire rx_pop   = rd_rx & ~rx_empty;
   logic tx_pop, rx_push, rx_store;
   logic [10:0] rx_word;
   assign rx_push = rx_store & ~rx_full;

   // Queue pointers; writes into a full transmit queue are dropped
   always_ff @(posedge i_core_clk) begin
      if (tx_push) txq[txw_reg] <= i_pwdata[8:0];
      if (rx_push) rxq[rxw_reg] <= rx_word;
      if (i_srst | tx_flush) begin
         txw_reg <= '0;
         txr_reg <= '0;
         txc_reg <= '0;
      end else begin
         if (tx_push) txw_reg <= nxt(txw_reg);
         if (tx_pop) txr_reg <= nxt(txr_reg);
         txc_reg <= txc_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
      if (i_srst | rx_flush) begin
         rxw_reg <= '0;
         rxr_reg <= '0;
         rxc_reg <= '0;
      end else begin
         if (rx_push) rxw_reg <= nxt(rxw_reg);
         if (rx_pop) rxr_reg <= nxt(rxr_reg);
         rxc_reg <= rxc_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   asp_st_t     tx_st_reg;
   logic [11:0] tx_sh_reg;
   logic [3:0]  tx_nb_reg, tx_tc_reg;
   logic        tx_pr_reg, tx_hp_reg, tx_two_reg, tx_brk_reg, tx_line_reg;
   logic        cts_s1_reg, cts_s2_reg, out_reg;
   wire cts_ok   = (puse != 2'b10) | mode_reg[`ASP_B_REQUEST_PIN_MODE] | ~cts_s2_reg;
   wire tx_go    = run & ~tx_flush & (tx_st_reg == ST_IDLE) & cts_ok;
   wire brk_go   = tx_go & brk_reg;
   assign tx_pop = tx_go & ~brk_reg & ~tx_empty;
   wire tx_bend  = tick & (tx_tc_reg == last);
   wire tx_done  = tx_bend & (tx_st_reg == ST_STOP) & ~tx_two_reg;
   wire [8:0] txd = txq[txr_reg];

   // Frame sequencer; bit timing restarts at each start bit
   always_ff @(posedge i_core_clk) begin
      if (i_srst | tx_flush) begin
         tx_st_reg  <= ST_IDLE;
         tx_tc_reg  <= 4'h0;
         tx_brk_reg <= 1'b0;
      end else if (brk_go | tx_pop) begin
         tx_st_reg  <= ST_START;
         tx_tc_reg  <= 4'h0;
         tx_brk_reg <= brk_go;
         tx_sh_reg  <= brk_go ? 12'h000 : {3'b000, txd};
         tx_nb_reg  <= brk_go ? `ASP_BRK_BITS : (nine ? 4'h9 : 4'h8);
         tx_hp_reg  <= ~brk_go & haspr;
         tx_pr_reg  <= par_of(txd[7:0], oddp);
         tx_two_reg <= ~brk_go & mode_reg[`ASP_B_STOP];
      end else if (tick) begin
         tx_tc_reg <= tx_bend ? 4'h0 : tx_tc_reg + 4'h1;
         if (tx_bend) begin
            unique case (tx_st_reg)
               ST_IDLE:  tx_st_reg <= ST_IDLE;
               ST_START: tx_st_reg <= ST_DATA;
               ST_DATA: begin
                  tx_sh_reg <= {1'b0, tx_sh_reg[11:1]};
                  tx_nb_reg <= tx_nb_reg - 4'h1;
                  if (tx_nb_reg == 4'h1) tx_st_reg <= tx_hp_reg ? ST_PAR : ST_STOP;
               end
               ST_PAR:   tx_st_reg <= ST_STOP;
               ST_STOP: begin
                  tx_two_reg <= 1'b0;
                  if (!tx_two_reg) tx_st_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Line level, then optional infrared pulse of 3/16 bit for zeros
   always_comb begin
      unique case (tx_st_reg)
         ST_START: tx_line_reg = 1'b0;
         ST_DATA:  tx_line_reg = tx_sh_reg[0];
         ST_PAR:   tx_line_reg = tx_pr_reg;
         default:  tx_line_reg = 1'b1;
      endcase
   end
   always_ff @(posedge i_core_clk) begin
      cts_s1_reg <= i_clear_to_send_pin_n;
      cts_s2_reg <= cts_s1_reg;
      if (i_srst) out_reg <= 1'b1;
      else if (lpbk) out_reg <= 1'b1;
      else if (ir_on) out_reg <= ~tx_line_reg & (tx_tc_reg < `ASP_IR_PULSE);
      else out_reg <= tx_line_reg;
   end
   assign o_serial_out_pin    = out_reg;
   assign o_serial_out_pin_oe = on & txen_reg;

   // Request pin: free-queue handshake, or asserted while sending
   wire rts_act = mode_reg[`ASP_B_REQUEST_PIN_MODE] ? (tx_st_reg != ST_IDLE) : ~rx_full;
   assign o_request_to_send_pin_n  = (puse == 2'b11) ? bclk_reg : ~rts_act;
   assign o_request_to_send_pin_oe = on & (puse != 2'b00);

   // ---------------------------------------------------------------
   // Receive front end: sync, infrared decode, polarity, loopback
   // ---------------------------------------------------------------
   logic       rx_s1_reg, rx_s2_reg, prev_reg;
   logic [4:0] ir_cnt_reg;
   always_ff @(posedge i_core_clk) begin
      rx_s1_reg <= i_serial_in_pin;
      rx_s2_reg <= rx_s1_reg;
      if (i_srst) ir_cnt_reg <= 5'h00;
      else if (rx_s2_reg) ir_cnt_reg <= `ASP_IR_HOLD;
      else if (tick && ir_cnt_reg != 5'h00) ir_cnt_reg <= ir_cnt_reg - 5'h01;
   end
   wire rx_pin = ir_on ? (ir_cnt_reg == 5'h00) : rx_s2_reg ^ mode_reg[`ASP_B_RINV];
   wire rxl    = lpbk ? tx_line_reg : rx_pin;
   always_ff @(posedge i_core_clk) prev_reg <= i_srst ? 1'b1 : rxl;
   wire fall = prev_reg & ~rxl;
   wire rise = ~prev_reg & rxl;

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   asp_st_t    rx_st_reg;
   logic [8:0] rx_sh_reg;
   logic [3:0] rx_nb_reg, rx_tc_reg;
   logic       rx_pe_reg;
   wire rx_mid = tick & (rx_tc_reg == half);
   wire rx_end = tick & (rx_tc_reg == last);
   wire [8:0] rx_d = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
   wire keep = ~(nine & address_detect_enable_reg) | rx_d[8];
   assign rx_store = rx_mid & (rx_st_reg == ST_STOP) & keep;
   assign rx_word  = {~rxl, rx_pe_reg, rx_d};

   // Bits sampled at mid-bit; returns to idle at mid-stop
   always_ff @(posedge i_core_clk) begin
      if (i_srst | rx_flush) begin
         rx_st_reg <= ST_IDLE;
         rx_tc_reg <= 4'h0;
      end else if (rx_st_reg == ST_IDLE) begin
         rx_tc_reg <= 4'h0;
         if (fall & run & ~abd) rx_st_reg <= ST_START;
      end else if (tick) begin
         rx_tc_reg <= rx_end ? 4'h0 : rx_tc_reg + 4'h1;
         unique case (rx_st_reg)
            ST_START: begin
               if (rx_mid & rxl) rx_st_reg <= ST_IDLE;
               if (rx_end) begin
                  rx_st_reg <= ST_DATA;
                  rx_nb_reg <= nine ? 4'h9 : 4'h8;
                  rx_pe_reg <= 1'b0;
               end
            end
            ST_DATA: begin
               if (rx_mid) rx_sh_reg <= {rxl, rx_sh_reg[8:1]};
               if (rx_end) begin
                  rx_nb_reg <= rx_nb_reg - 4'h1;
                  if (rx_nb_reg == 4'h1) rx_st_reg <= haspr ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: begin
               if (rx_mid) rx_pe_reg <= rxl ^ par_of(rx_d[7:0], oddp);
               if (rx_end) rx_st_reg <= ST_STOP;
            end
            ST_STOP:  if (rx_mid) rx_st_reg <= ST_IDLE;
            default:  rx_st_reg <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Auto-rate: five falling edges of 55h span eight bit times
   // ---------------------------------------------------------------
   logic [ABW-1:0] ab_cnt_reg;
   logic [2:0]     ab_fall_reg;
   wire ab_done = abd & run & fall & (ab_fall_reg == `ASP_AB_FALLS);
   wire [ABW-1:0] ab_q = high_speed_sampling ? ab_cnt_reg >> `ASP_AB_SH_HS : ab_cnt_reg >> `ASP_AB_SH_STD;
   always_ff @(posedge i_core_clk) begin
      if (i_srst | ~abd | ab_done) begin
         ab_cnt_reg  <= '0;
         ab_fall_reg <= 3'h0;
      end else if (run) begin
         if (fall) ab_fall_reg <= ab_fall_reg + 3'h1;
         // Count from the first edge itself, else truncation loses a step
         if (fall || ab_fall_reg != 3'h0) ab_cnt_reg <= ab_cnt_reg + ABW'(1);
      end
   end

   // ---------------------------------------------------------------
   // Wake from sleep
   // ---------------------------------------------------------------
   logic wake_seen_reg, wake_irq_reg;
   wire wk = mode_reg[`ASP_B_WAKE] & i_sleep;
   wire wake_clr = wk & wake_seen_reg & rise;
   always_ff @(posedge i_core_clk) begin
      wake_irq_reg  <= ~i_srst & wk & fall;
      if (i_srst | ~mode_reg[`ASP_B_WAKE]) wake_seen_reg <= 1'b0;
      else if (wk & fall) wake_seen_reg <= 1'b1;
   end

   // ---------------------------------------------------------------
   // Register updates: hardware set wins over software clear
   // ---------------------------------------------------------------
   always_comb begin
      mode_next = wr_md ? (i_pwdata[15:0] & `ASP_MODE_WMASK) : mode_reg;
      if (ab_done && !(wr_md && i_pwdata[`ASP_B_AUTO_RATE_MEASURE])) mode_next[`ASP_B_AUTO_RATE_MEASURE] = 1'b0;
      if (wake_clr && !(wr_md && i_pwdata[`ASP_B_WAKE])) mode_next[`ASP_B_WAKE] = 1'b0;
      brk_next = wr_st ? i_pwdata[`ASP_B_BRK] : brk_reg;
      if (tx_done && tx_brk_reg && !(wr_st && i_pwdata[`ASP_B_BRK])) brk_next = 1'b0;
      overrun_flag_next = overrun_flag_reg & ~(wr_st & ~i_pwdata[`ASP_B_OVERRUN_FLAG]);
      if (rx_store & rx_full) overrun_flag_next = 1'b1;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         mode_reg  <= `ASP_MODE_RST;
         div_reg   <= `ASP_DIV_RST;
         brk_reg   <= 1'b0;
         txen_reg  <= 1'b0;
         address_detect_enable_reg <= 1'b0;
         overrun_flag_reg  <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         brk_reg  <= brk_next;
         overrun_flag_reg <= overrun_flag_next;
         if (wr_st) txen_reg <= i_pwdata[`ASP_B_TXEN];
         if (wr_st) address_detect_enable_reg <= i_pwdata[`ASP_B_ADDRESS_DETECT_ENABLE];
         if (ab_done) div_reg <= ab_q[15:0] - 16'h0001;
         else if (wr & hit_dv) div_reg <= i_pwdata[15:0];
      end
   end

   // Status word; parity and framing flags follow the queue head
   wire [15:0] stat = {4'h0, brk_reg, txen_reg, tx_full,
                       tx_empty & (tx_st_reg == ST_IDLE),
                       2'b00, address_detect_enable_reg, rx_st_reg == ST_IDLE,
                       ~rx_empty & rx_head[9], ~rx_empty & rx_head[10],
                       overrun_flag_reg, ~rx_empty};
   wire [15:0] rsel = hit_md ? mode_reg : hit_st ? stat : hit_dv ? div_reg :
                      hit_rx ? {7'h00, rx_head[8:0]} : 16'h0000;

   // Read data latched in the setup cycle, held through access
   always_ff @(posedge i_core_clk) begin
      if (i_srst) prdata_reg <= 32'h0000_0000;
      else if (i_psel & ~i_penable & ~i_pwrite) prdata_reg <= {16'h0000, rsel};
   end

   assign o_tx_irq   = on & txen_reg & ~tx_full;
   assign o_rx_irq   = ~rx_empty;
   assign o_err_irq  = overrun_flag_reg | (~rx_empty & (rx_head[9] | rx_head[10]));
   assign o_wake_irq = wake_irq_reg;
endmodule : asp_top
